// >>> bench/nic_src_model.sv
/*
 Far-side model: the on-chip event sources feeding the interrupt controller.
 Assumes the bench asks for events by plain command vectors, one cycle per pulse.
*/
`timescale 1ns/1ps
module nic_src_model
    import nic_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        nrst,
    // Commands from the bench
    input  wire logic [9:0]  nmi_fire,
    input  wire logic [11:0] irq_fire,
    input  wire logic [2:0]  lvl_req,
    // Event lines toward the controller
    output nic_evt_t         evt
);
    // Pulses and levels launched just after the edge, as real sources do
    always_ff @(posedge clk) begin
        if (!nrst) begin
            evt <= '0;
        end else begin
            evt.nmi_evt       <= nmi_fire;
            evt.irq_evt       <= irq_fire;
            evt.uart_req      <= lvl_req[2];
            evt.user_uart_req <= lvl_req[1];
            evt.adc_req       <= lvl_req[0];
        end
    end
endmodule : nic_src_model

// >>> bench/testbench.sv
/*
 Self-checking bench of the interrupt controller: register access, flags, ranking, vectors.
 Assumes the one-wait-state Avalon-MM slave and registered core request of the design.
*/
`timescale 1ns/1ps
module testbench
    import nic_pkg::*;
;
    // Clock, reset, bus and event wiring
    logic        clk = 1'b0;
    logic        nrst;
    logic [15:0] avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    nic_evt_t    evt;
    nic_core_t   core_q;
    logic [9:0]  nmi_fire;
    logic [11:0] irq_fire;
    logic [2:0]  lvl_req;
    logic [31:0] rd;
    int          fail_count = 0;
    int          cmp_count = 0;
    // Reset-value sweep, enable patterns and clear steps in rank order
    localparam logic [15:0] R_IDX [12] = '{IDX_NMI_EN_LO, IDX_NMI_EN_HI, IDX_NMI_PND_LO,
        IDX_NMI_PND_HI, IDX_NMI_CLR_LO, IDX_NMI_CLR_HI, IDX_IRQ_EN_LO, IDX_IRQ_EN_HI,
        IDX_IRQ_PND_LO, IDX_IRQ_PND_HI, IDX_VECTORING_CONTROL, 16'h1050};
    localparam logic [15:0] E_IDX [4] = '{IDX_NMI_EN_LO, IDX_NMI_EN_HI, IDX_IRQ_EN_LO,
        IDX_IRQ_EN_HI};
    localparam logic [7:0]  E_VAL [4] = '{8'h7f, 8'h07, 8'h3f, 8'h3f};
    localparam logic [15:0] N_IDX [8] = '{IDX_NMI_CLR_LO, IDX_NMI_CLR_HI, IDX_NMI_CLR_LO,
        IDX_NMI_CLR_LO, IDX_NMI_CLR_LO, IDX_NMI_CLR_LO, IDX_NMI_CLR_LO, IDX_NMI_CLR_HI};
    localparam logic [7:0]  N_MSK [8] = '{8'h08, 8'h01, 8'h10, 8'h02, 8'h20, 8'h04, 8'h40,
        8'h0e};
    // Index zero marks a level source, dropped by the low bits of the mask
    localparam logic [15:0] I_IDX [11] = '{16'h0000, IDX_IRQ_CLR_LO, IDX_IRQ_CLR_LO,
        IDX_IRQ_CLR_LO, IDX_IRQ_CLR_LO, IDX_IRQ_CLR_LO, IDX_IRQ_CLR_LO, 16'h0000,
        IDX_IRQ_CLR_HI, 16'h0000, IDX_IRQ_CLR_HI};
    localparam logic [7:0]  I_MSK [11] = '{8'h04, 8'h01, 8'h10, 8'h02, 8'h20, 8'h04, 8'h40,
        8'h02, 8'h07, 8'h01, 8'h70};

    // Design and far-side model
    nic_top i_nic_top (
        .clk             (clk),
        .nrst            (nrst),
        .avs_address     (avs_address),
        .avs_read        (avs_read),
        .avs_write       (avs_write),
        .avs_writedata   (avs_writedata),
        .avs_byteenable  (4'h1),
        .avs_readdata    (avs_readdata),
        .avs_waitrequest (avs_waitrequest),
        .evt             (evt),
        .core_q          (core_q)
    );
    nic_src_model i_nic_src_model (
        .clk      (clk),
        .nrst     (nrst),
        .nmi_fire (nmi_fire),
        .irq_fire (irq_fire),
        .lvl_req  (lvl_req),
        .evt      (evt)
    );

    // Free-running 40 MHz clock
    always #12.5 clk = ~clk;

    // Compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // One bus cycle; request held until waitrequest is seen low at an edge
    task automatic bus(input logic wr, input logic [15:0] idx, input logic [7:0] wd);
        int   n;
        @(posedge clk);
        avs_address   <= {idx[13:0], 2'b00};
        avs_writedata <= {24'h000000, wd};
        avs_write     <= wr;
        avs_read      <= ~wr;
        n = 0;
        // Waitrequest and read data are taken at the rising edge itself
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 100);
        rd = avs_readdata;
        if (n >= 100) begin
            fail_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, 32'h1, 32'h0);
        end
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask : bus

    task automatic wr(input logic [15:0] idx, input logic [7:0] d);
        bus(1'b1, idx, d);
    endtask : wr

    task automatic rdchk(input logic [15:0] idx, input logic [7:0] exp);
        bus(1'b0, idx, 8'h00);
        chk(rd, {24'h000000, exp});
    endtask : rdchk

    // One-cycle event pulses through the model
    task automatic fire(input logic [9:0] n, input logic [11:0] i);
        @(posedge clk);
        nmi_fire <= n;
        irq_fire <= i;
        @(posedge clk);
        nmi_fire <= '0;
        irq_fire <= '0;
    endtask : fire

    // Let the request settle, then compare the whole core bundle
    task automatic core(input logic n, input logic i, input logic [3:0] s, input logic [15:0] v);
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk({10'h000, core_q}, {10'h000, n, i, s, v});
    endtask : core

    // Counts, verdict and end of run
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : close_out

    // Hang guard, far beyond the few hundred cycles the tests take
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        close_out();
    end

    // Test sequence
    initial begin
        nrst = 1'b0;
        avs_address = '0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = '0;
        nmi_fire = '0;
        irq_fire = '0;
        lvl_req = '0;
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        for (int k = 0; k < 12; k++) rdchk(R_IDX[k], 8'h00);
        $display("test reset done");
        for (int k = 0; k < 4; k++) begin
            wr(E_IDX[k], E_VAL[k]);
            rdchk(E_IDX[k], E_VAL[k]);
        end
        wr(IDX_NMI_EN_LO, 8'h00);
        $display("test enables done");
        // Disabled watchdog line: flag sets, no request until enabled
        fire(10'h008, 12'h000);
        core(1'b0, 1'b0, 4'h0, 16'h0000);
        rdchk(IDX_NMI_PND_LO, 8'h08);
        wr(IDX_NMI_EN_LO, 8'h7f);
        core(1'b1, 1'b0, 4'h0, 16'hfffa);
        wr(IDX_VECTORING_CONTROL, 8'h80);
        rdchk(IDX_VECTORING_CONTROL, 8'h80);
        // All non-maskable sources at once, retired one rank at a time
        fire(10'h3ff, 12'h000);
        rdchk(IDX_NMI_PND_LO, 8'h7f);
        rdchk(IDX_NMI_PND_HI, 8'h07);
        wr(IDX_NMI_CLR_LO, 8'h00);
        wr(IDX_NMI_CLR_HI, 8'h00);
        rdchk(IDX_NMI_PND_LO, 8'h7f);
        for (int k = 0; k < 8; k++) begin
            core(1'b1, 1'b0, k[3:0], 16'hffee - {11'h000, k[3:0], 1'b0});
            wr(N_IDX[k], N_MSK[k]);
        end
        core(1'b0, 1'b0, 4'h0, 16'h0000);
        rdchk(IDX_NMI_PND_LO, 8'h00);
        rdchk(IDX_NMI_PND_HI, 8'h00);
        $display("test nmi done");
        // All maskable sources, with a non-maskable one cutting in
        wr(IDX_VECTORING_CONTROL, 8'hc0);
        @(posedge clk);
        lvl_req <= 3'b111;
        fire(10'h000, 12'hfff);
        rdchk(IDX_IRQ_PND_LO, 8'h3f);
        rdchk(IDX_IRQ_PND_HI, 8'h77);
        fire(10'h008, 12'h000);
        core(1'b1, 1'b0, 4'h0, 16'hffee);
        wr(IDX_NMI_CLR_LO, 8'h08);
        wr(IDX_RANK_PREF, 8'h8a);
        core(1'b0, 1'b1, 4'ha, 16'hffba);
        wr(IDX_RANK_PREF, 8'h00);
        for (int k = 0; k < 11; k++) begin
            core(1'b0, 1'b1, k[3:0], 16'hffce - {11'h000, k[3:0], 1'b0});
            if (I_IDX[k] == 16'h0000) begin
                @(posedge clk);
                lvl_req <= lvl_req & ~I_MSK[k][2:0];
            end else begin
                wr(I_IDX[k], I_MSK[k]);
            end
        end
        core(1'b0, 1'b0, 4'h0, 16'h0000);
        rdchk(IDX_IRQ_PND_LO, 8'h00);
        rdchk(IDX_IRQ_PND_HI, 8'h00);
        $display("test irq done");
        close_out();
    end
endmodule : testbench

// >>> common/nic_pkg.sv
/*
 Constants, register map and carrier types of the interrupt controller.
 Assumes a 32-bit word-per-register slave bus and a synchronous system clock.
*/
package nic_pkg;
    // Slot and line counts
    localparam int NMI_N = 10;
    localparam int IRQ_N = 12;
    localparam int NSLOT = 8;
    localparam int ISLOT = 11;
    // Register indices; byte address is four times the index
    localparam logic [15:0] IDX_NMI_EN_LO  = 16'h1000;
    localparam logic [15:0] IDX_NMI_EN_HI  = 16'h1001;
    localparam logic [15:0] IDX_NMI_PND_LO = 16'h1002;
    localparam logic [15:0] IDX_NMI_PND_HI = 16'h1003;
    localparam logic [15:0] IDX_NMI_CLR_LO = 16'h1004;
    localparam logic [15:0] IDX_NMI_CLR_HI = 16'h1005;
    localparam logic [15:0] IDX_IRQ_EN_LO  = 16'h1006;
    localparam logic [15:0] IDX_IRQ_EN_HI  = 16'h1007;
    localparam logic [15:0] IDX_IRQ_PND_LO = 16'h1008;
    localparam logic [15:0] IDX_IRQ_PND_HI = 16'h1009;
    localparam logic [15:0] IDX_IRQ_CLR_LO = 16'h100a;
    localparam logic [15:0] IDX_IRQ_CLR_HI = 16'h100b;
    localparam logic [15:0] IDX_VECTORING_CONTROL    = 16'h1068;
    localparam logic [15:0] IDX_RANK_PREF  = 16'h1070;
    // Non-maskable flag positions (low register keeps these positions)
    localparam int NF_P1 = 0;
    localparam int NF_P2 = 1;
    localparam int NF_P3 = 2;
    localparam int NF_WD = 3;
    localparam int NF_T1 = 4;
    localparam int NF_T2 = 5;
    localparam int NF_T3 = 6;
    localparam int NF_2HZ = 7;
    localparam int NF_1HZ = 8;
    localparam int NF_1MIN = 9;
    // Maskable flag positions (enable pair concatenates to this order)
    localparam int MF_P1 = 0;
    localparam int MF_P2 = 1;
    localparam int MF_P3 = 2;
    localparam int MF_T1 = 3;
    localparam int MF_T2 = 4;
    localparam int MF_T3 = 5;
    localparam int MF_2HZ = 6;
    localparam int MF_1HZ = 7;
    localparam int MF_1MIN = 8;
    localparam int MF_TB64 = 9;
    localparam int MF_TB512 = 10;
    localparam int MF_TB2048 = 11;
    // Control register fields and reset values
    localparam int VC_NMI_BIT = 7;
    localparam int VC_IRQ_BIT = 6;
    localparam int PREF_EN_BIT = 7;
    localparam logic [7:0] EN_RST = 8'h00;
    // Vectors
    localparam logic [15:0] NMI_VEC_TOP = 16'hffee;
    localparam logic [15:0] IRQ_VEC_TOP = 16'hffce;
    localparam logic [15:0] NMI_VEC_DFLT = 16'hfffa;
    localparam logic [15:0] IRQ_VEC_DFLT = 16'hfffe;

    // Event sources: pulses set flags, level requests pass through
    typedef struct packed {
        logic [NMI_N-1:0] nmi_evt;
        logic [IRQ_N-1:0] irq_evt;
        logic             uart_req;
        logic             user_uart_req;
        logic             adc_req;
    } nic_evt_t;

    // Request toward the core
    typedef struct packed {
        logic        nmi;
        logic        irq;
        logic [3:0]  slot;
        logic [15:0] vector;
    } nic_core_t;

    // Byte address of a register index
    function automatic logic [15:0] reg_addr(input logic [15:0] idx);
        return {idx[13:0], 2'b00};
    endfunction : reg_addr

    // Two-byte vector of a slot below a top vector
    function automatic logic [15:0] slot_vec(input logic [15:0] top, input logic [3:0] slot);
        return top - {11'h000, slot, 1'b0};
    endfunction : slot_vec
endpackage : nic_pkg

// >>> hdl/nic_flag_bank.sv
/*
 Bank of sticky pending flags; a set in the clearing cycle survives.
 Assumes set and clear pulses synchronous to clk.
*/
`timescale 1ns/1ps
module nic_flag_bank
    import nic_pkg::*;
#(
    parameter int W = 10
) (
    // Clock and reset
    input  logic         clk,
    input  logic         nrst,
    // Set and clear pulses
    input  logic [W-1:0] set,
    input  logic [W-1:0] clr,
    // Flags
    output logic [W-1:0] flag_q
);
    // Set wins over clear; zero in clr leaves a flag alone
    always_ff @(posedge clk) begin
        if (!nrst) begin
            flag_q <= '0;
        end else begin
            flag_q <= (flag_q & ~clr) | set;
        end
    end

    AST_SET_WINS: assert property (@(posedge clk) disable iff (!nrst)
        (set != '0) |=> ((flag_q & $past(set)) == $past(set)))
        else $error("flag lost while set");
    AST_CLEAR_ONE: assert property (@(posedge clk) disable iff (!nrst)
        (clr != '0) |=> ((flag_q & $past(clr) & ~$past(set)) == '0))
        else $error("flag survived its clear");
endmodule : nic_flag_bank

// >>> hdl/nic_prio_pick.sv
/*
 Fixed-order priority picker: lowest requesting index wins.
 Assumes purely combinational use inside a clocked parent.
*/
`timescale 1ns/1ps
module nic_prio_pick
    import nic_pkg::*;
#(
    parameter int N  = 8,
    parameter int IW = 4
) (
    // Requests
    input  logic [N-1:0]  req,
    // Result
    output logic          any,
    output logic [IW-1:0] idx
);
    // Scan from the top down so the lowest index is left standing
    always_comb begin
        idx = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (req[i]) begin
                idx = IW'(i);
            end
        end
    end

    assign any = |req;
endmodule : nic_prio_pick

// >>> hdl/nic_top.sv
/*
 Interrupt controller: enable and pending registers, clear registers,
 fixed ranking with one software-raised slot, and vector generation.
 Assumes an Avalon-MM master with waitrequest and on-chip event sources.
*/
`timescale 1ns/1ps
module nic_top
    import nic_pkg::*;
(
    // Clock and reset
    input  logic        clk,
    input  logic        nrst,
    // Avalon-MM slave
    input  logic [15:0] avs_address,
    input  logic        avs_read,
    input  logic        avs_write,
    input  logic [31:0] avs_writedata,
    input  logic [3:0]  avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic        avs_waitrequest,
    // Event sources
    input  nic_evt_t    evt,
    // Request toward the core
    output nic_core_t   core_q
);
    logic              ack_q;
    logic              wr_fire;
    logic [7:0]        wdat;
    logic [6:0]        nmi_en_lo_q;
    logic [2:0]        nmi_en_hi_q;
    logic [5:0]        irq_en_lo_q;
    logic [5:0]        irq_en_hi_q;
    logic [1:0]        vectoring_control_q;
    logic [4:0]        pref_q;
    logic [NMI_N-1:0]  nmi_clr;
    logic [IRQ_N-1:0]  irq_clr;
    logic [NMI_N-1:0]  nmi_flag;
    logic [IRQ_N-1:0]  irq_flag;
    logic [NMI_N-1:0]  nmi_act;
    logic [IRQ_N-1:0]  irq_act;
    logic [NSLOT-1:0]  nslot_req;
    logic [ISLOT-1:0]  islot_req;
    logic              n_any;
    logic              i_any;
    logic [3:0]        n_idx;
    logic [3:0]        i_idx;
    logic [3:0]        i_win;
    logic              pref_hit;
    logic [7:0]        rd_d;
    logic [31:0]       readdata_q;

    // One wait state: request seen, answer on the next edge
    always_ff @(posedge clk) begin
        if (!nrst) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= (avs_read | avs_write) & ~ack_q;
        end
    end

    assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
    assign wr_fire = avs_write & ack_q & avs_byteenable[0];
    assign wdat = avs_writedata[7:0];

    // Enable, vectoring and rank preference registers
    always_ff @(posedge clk) begin
        if (!nrst) begin
            nmi_en_lo_q <= EN_RST[6:0];
            nmi_en_hi_q <= EN_RST[2:0];
            irq_en_lo_q <= EN_RST[5:0];
            irq_en_hi_q <= EN_RST[5:0];
            vectoring_control_q   <= EN_RST[1:0];
            pref_q      <= EN_RST[4:0];
        end else if (wr_fire) begin
            unique case (avs_address)
                reg_addr(IDX_NMI_EN_LO): nmi_en_lo_q <= wdat[6:0];
                reg_addr(IDX_NMI_EN_HI): nmi_en_hi_q <= wdat[2:0];
                reg_addr(IDX_IRQ_EN_LO): irq_en_lo_q <= wdat[5:0];
                reg_addr(IDX_IRQ_EN_HI): irq_en_hi_q <= wdat[5:0];
                reg_addr(IDX_VECTORING_CONTROL): vectoring_control_q <= {wdat[VC_NMI_BIT], wdat[VC_IRQ_BIT]};
                reg_addr(IDX_RANK_PREF): pref_q <= {wdat[PREF_EN_BIT], wdat[3:0]};
                default: ;
            endcase
        end
    end

    // Write-one clear pulses; zeros in the data clear nothing
    always_comb begin
        nmi_clr = '0;
        irq_clr = '0;
        if (wr_fire && avs_address == reg_addr(IDX_NMI_CLR_LO)) begin
            nmi_clr[NF_T3:NF_P2] = wdat[6:1];
        end
        if (wr_fire && avs_address == reg_addr(IDX_NMI_CLR_HI)) begin
            nmi_clr[NF_P1]   = wdat[0];
            nmi_clr[NF_1MIN] = wdat[1];
            nmi_clr[NF_1HZ]  = wdat[2];
            nmi_clr[NF_2HZ]  = wdat[3];
        end
        if (wr_fire && avs_address == reg_addr(IDX_IRQ_CLR_LO)) begin
            irq_clr[MF_P3:MF_P1] = wdat[2:0];
            irq_clr[MF_T3:MF_T1] = wdat[6:4];
        end
        if (wr_fire && avs_address == reg_addr(IDX_IRQ_CLR_HI)) begin
            irq_clr[MF_1MIN:MF_2HZ]   = wdat[2:0];
            irq_clr[MF_TB2048:MF_TB64] = wdat[6:4];
        end
    end

    // Pending flags for both classes
    nic_flag_bank #(.W(NMI_N)) u_nmi_flags (
        .clk    (clk),
        .nrst   (nrst),
        .set    (evt.nmi_evt),
        .clr    (nmi_clr),
        .flag_q (nmi_flag)
    );

    nic_flag_bank #(.W(IRQ_N)) u_irq_flags (
        .clk    (clk),
        .nrst   (nrst),
        .set    (evt.irq_evt),
        .clr    (irq_clr),
        .flag_q (irq_flag)
    );

    // A pulse line requests only while flag and enable are both set; level requests bypass both
    assign nmi_act = nmi_flag & {nmi_en_hi_q, nmi_en_lo_q};
    assign irq_act = irq_flag & {irq_en_hi_q, irq_en_lo_q};

    // Gather lines into rank slots
    assign nslot_req = {|nmi_act[NF_1MIN:NF_2HZ], nmi_act[NF_T3], nmi_act[NF_P3],
                        nmi_act[NF_T2], nmi_act[NF_P2], nmi_act[NF_T1],
                        nmi_act[NF_P1], nmi_act[NF_WD]};
    assign islot_req = {|irq_act[MF_TB2048:MF_TB64], evt.adc_req,
                        |irq_act[MF_1MIN:MF_2HZ], evt.user_uart_req,
                        irq_act[MF_T3], irq_act[MF_P3], irq_act[MF_T2],
                        irq_act[MF_P2], irq_act[MF_T1], irq_act[MF_P1],
                        evt.uart_req};

    nic_prio_pick #(.N(NSLOT), .IW(4)) u_nmi_pick (
        .req (nslot_req),
        .any (n_any),
        .idx (n_idx)
    );

    nic_prio_pick #(.N(ISLOT), .IW(4)) u_irq_pick (
        .req (islot_req),
        .any (i_any),
        .idx (i_idx)
    );

    // Software-raised maskable slot overrides the fixed order
    assign pref_hit = pref_q[4] && (pref_q[3:0] < 4'(ISLOT)) &&
                      islot_req[pref_q[3:0]];
    assign i_win = pref_hit ? pref_q[3:0] : i_idx;

    // Core request: non-maskable always ahead of maskable
    always_ff @(posedge clk) begin
        if (!nrst) begin
            core_q <= '0;
        end else begin
            core_q.nmi <= n_any;
            core_q.irq <= i_any & ~n_any;
            if (n_any) begin
                core_q.slot   <= n_idx;
                core_q.vector <= vectoring_control_q[1] ? slot_vec(NMI_VEC_TOP, n_idx)
                                              : NMI_VEC_DFLT;
            end else if (i_any) begin
                core_q.slot   <= i_win;
                core_q.vector <= vectoring_control_q[0] ? slot_vec(IRQ_VEC_TOP, i_win)
                                              : IRQ_VEC_DFLT;
            end else begin
                core_q.slot   <= 4'h0;
                core_q.vector <= 16'h0000;
            end
        end
    end

    // Read multiplexer; unmapped and write-only offsets read zero
    always_comb begin
        rd_d = 8'h00;
        unique case (avs_address)
            reg_addr(IDX_NMI_EN_LO): rd_d = {1'b0, nmi_en_lo_q};
            reg_addr(IDX_NMI_EN_HI): rd_d = {5'h00, nmi_en_hi_q};
            reg_addr(IDX_NMI_PND_LO): rd_d = {1'b0, nmi_flag[NF_T3:NF_P1]};
            reg_addr(IDX_NMI_PND_HI): rd_d = {5'h00, nmi_flag[NF_1MIN:NF_2HZ]};
            reg_addr(IDX_IRQ_EN_LO): rd_d = {2'h0, irq_en_lo_q};
            reg_addr(IDX_IRQ_EN_HI): rd_d = {2'h0, irq_en_hi_q};
            reg_addr(IDX_IRQ_PND_LO): rd_d = {2'h0, irq_flag[MF_P3:MF_P1],
                                              irq_flag[MF_T3:MF_T1]};
            reg_addr(IDX_IRQ_PND_HI): rd_d = {1'b0, irq_flag[MF_TB2048:MF_TB64], 1'b0,
                                              irq_flag[MF_1MIN:MF_2HZ]};
            reg_addr(IDX_VECTORING_CONTROL): rd_d = {vectoring_control_q, 6'h00};
            reg_addr(IDX_RANK_PREF): rd_d = {pref_q[4], 3'h0, pref_q[3:0]};
            default: rd_d = 8'h00;
        endcase
    end

    // Read data captured on the wait cycle, stands on the answer edge
    always_ff @(posedge clk) begin
        if (!nrst) begin
            readdata_q <= 32'h0000_0000;
        end else if (avs_read && !ack_q) begin
            readdata_q <= {24'h000000, rd_d};
        end
    end

    assign avs_readdata = readdata_q;

    AST_BUS_ONE_WAIT: assert property (@(posedge clk) disable iff (!nrst)
        ((avs_read || avs_write) && avs_waitrequest) |=> !avs_waitrequest)
        else $error("bus answer not after one wait cycle");
    AST_ENABLES_RESET: assert property (@(posedge clk)
        !nrst |=> (nmi_en_lo_q == 7'h00 && nmi_en_hi_q == 3'h0 &&
                   irq_en_lo_q == 6'h00 && irq_en_hi_q == 6'h00))
        else $error("enables not zero after reset");
    AST_NMI_BEFORE_IRQ: assert property (@(posedge clk) disable iff (!nrst)
        (nslot_req != '0) |=> (core_q.nmi && !core_q.irq))
        else $error("maskable request served ahead of non-maskable");
    AST_WATCHDOG_FIRST: assert property (@(posedge clk) disable iff (!nrst)
        nmi_act[NF_WD] |=> (core_q.slot == 4'h0))
        else $error("watchdog slot not ranked first");
    AST_NMI_VECTOR: assert property (@(posedge clk) disable iff (!nrst)
        (core_q.nmi && $past(vectoring_control_q[1])) |->
            core_q.vector == 16'hffee - {11'h000, core_q.slot, 1'b0})
        else $error("non-maskable vector wrong");
    AST_IRQ_VECTOR: assert property (@(posedge clk) disable iff (!nrst)
        (core_q.irq && $past(vectoring_control_q[0])) |->
            core_q.vector == 16'hffce - {11'h000, core_q.slot, 1'b0})
        else $error("maskable vector wrong");
    AST_TIMEBASE_LAST: assert property (@(posedge clk) disable iff (!nrst)
        (core_q.irq && core_q.slot == 4'ha && !$past(pref_hit)) |->
            $past(islot_req[9:0]) == 10'h000)
        else $error("time-base slot won over a higher slot");
    AST_DISABLED_SILENT: assert property (@(posedge clk) disable iff (!nrst)
        (irq_en_lo_q == 6'h00 && irq_en_hi_q == 6'h00 && !evt.uart_req &&
         !evt.user_uart_req && !evt.adc_req) |=> !core_q.irq)
        else $error("maskable request with every source disabled");
endmodule : nic_top
